// [logic/pin_select_map.svh]
// register offsets, field positions, reset values for the port d/e pin selector
`ifndef PIN_SELECT_MAP_SVH
`define PIN_SELECT_MAP_SVH

`define PSEL_ADDR_W          4
`define PSEL_OFS_D_LOW_FSEL  4'h0
`define PSEL_OFS_E_DIR       4'h2
`define PSEL_OFS_E_UP_FSEL   4'h4
`define PSEL_OFS_E_LOW_FSEL  4'h6

`define PSEL_RST_D_LOW_FSEL  16'h0000
`define PSEL_RST_E_DIR       16'h0000
`define PSEL_RST_E_UP_FSEL   16'h0000
`define PSEL_RST_E_LOW_FSEL  16'h0000

`define PSEL_E_UP_WMASK      16'hf000
`define PSEL_E15_HI          15
`define PSEL_E15_LO          14
`define PSEL_E14_HI          13
`define PSEL_E14_LO          12

`define PSEL_CODE_GPIO       2'h0
`define PSEL_CODE_DMA_ACK    2'h2
`define PSEL_CODE_ADDR_HOLD  2'h3

`endif

// [logic/pin_select_pkg.sv]
// types shared by the port d/e pin selector
package pin_select_pkg;

  typedef enum logic [1:0] {
    MODE_ROM_DISABLED,
    MODE_ROM_ENABLED,
    MODE_SINGLE_CHIP
  } op_mode_t;

  typedef enum logic [1:0] {
    FN_GPIO,
    FN_DMA_ACK,
    FN_ADDR_HOLD
  } e_upper_fn_t;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } pin_drive_t;

endpackage

// [logic/port_d_e_pin_function_select.sv]
// pin function selection for ports d and e
//
// Overview of operation
// - d mode 0 gpio, bus when rom disabled
// - d mode 1 data bus, gpio in single-chip
// - e direction bit n maps pin n
// - e direction 1 output, 0 input
// - e direction only for gpio/timer functions
// - e direction cleared only by power-on reset
// - e function selects cleared only by power-on
// - upper register pins 15-8, lower 7-0
// - six-port single-chip ignores dma/hold selects
// - pin15 field 00 gpio, 10 dma ack1
// - pin14 field 00 gpio, 10 ack0, 11 hold
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "pin_select_map.svh"

module port_d_e_pin_function_select #(
  parameter bit SIX_PORTS = 1'b1
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_nrst,
  input  wire pin_select_pkg::op_mode_t   i_op_mode,
  input  wire logic [`PSEL_ADDR_W-1:0]    i_addr,
  input  wire logic [15:0]                i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic [15:0]                     o_rdata,
  input  wire pin_select_pkg::pin_drive_t i_d_gpio,
  input  wire pin_select_pkg::pin_drive_t i_d_bus,
  input  wire logic [15:0]                i_e_gpio_out,
  input  wire logic                       i_dma_ch1_acknowledge_out,
  input  wire logic                       i_dma_ch0_acknowledge_out,
  input  wire logic                       i_address_hold_out,
  output pin_select_pkg::pin_drive_t      o_d_pin,
  output logic [15:0]                     o_d_bus_sel,
  output pin_select_pkg::pin_drive_t      o_e_pin,
  output pin_select_pkg::e_upper_fn_t     o_e15_fn,
  output pin_select_pkg::e_upper_fn_t     o_e14_fn
);

  logic [15:0]                 port_d_low_function_select_reg;
  logic [15:0]                 port_e_direction_reg;
  logic [15:0]                 port_e_upper_function_select_reg;
  logic [15:0]                 port_e_lower_function_select_reg;
  logic [15:0]                 d_bus_sel_next;
  logic [15:0]                 e_dir_ok_next;
  pin_select_pkg::pin_drive_t  d_pin_next;
  pin_select_pkg::pin_drive_t  e_pin_next;
  pin_select_pkg::e_upper_fn_t e15_fn_next;
  pin_select_pkg::e_upper_fn_t e14_fn_next;
  logic                        dma_fn_blocked;

  // decode one upper pin field; reserved codes fall back to gpio
  function automatic pin_select_pkg::e_upper_fn_t dec_upper(
    input logic [1:0] code,
    input logic       hold_ok,
    input logic       blocked
  );
    pin_select_pkg::e_upper_fn_t fn;
    fn = pin_select_pkg::FN_GPIO;
    if (!blocked) begin
      if (code == `PSEL_CODE_DMA_ACK) begin
        fn = pin_select_pkg::FN_DMA_ACK;
      end else if (hold_ok && code == `PSEL_CODE_ADDR_HOLD) begin
        fn = pin_select_pkg::FN_ADDR_HOLD;
      end
    end
    return fn;
  endfunction

  // power-on only clear
  // watchdog/standby/sleep never reach i_nrst, so contents survive them
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      port_e_direction_reg <= `PSEL_RST_E_DIR;
    end else if (i_wr && i_addr == `PSEL_OFS_E_DIR) begin
      port_e_direction_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      port_e_upper_function_select_reg <= `PSEL_RST_E_UP_FSEL;
      port_e_lower_function_select_reg <= `PSEL_RST_E_LOW_FSEL;
    end else if (i_wr) begin
      if (i_addr == `PSEL_OFS_E_UP_FSEL) begin
        port_e_upper_function_select_reg <= i_wdata & `PSEL_E_UP_WMASK;
      end
      if (i_addr == `PSEL_OFS_E_LOW_FSEL) begin
        port_e_lower_function_select_reg <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      port_d_low_function_select_reg <= `PSEL_RST_D_LOW_FSEL;
    end else if (i_wr && i_addr == `PSEL_OFS_D_LOW_FSEL) begin
      port_d_low_function_select_reg <= i_wdata;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        `PSEL_OFS_D_LOW_FSEL: o_rdata <= port_d_low_function_select_reg;
        `PSEL_OFS_E_DIR:      o_rdata <= port_e_direction_reg;
        `PSEL_OFS_E_UP_FSEL:  o_rdata <= port_e_upper_function_select_reg & `PSEL_E_UP_WMASK;
        `PSEL_OFS_E_LOW_FSEL: o_rdata <= port_e_lower_function_select_reg;
        default:              o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // port d routing
  always_comb begin
    case (i_op_mode)
      pin_select_pkg::MODE_ROM_DISABLED: d_bus_sel_next = 16'hffff;
      pin_select_pkg::MODE_ROM_ENABLED:  d_bus_sel_next = port_d_low_function_select_reg;
      pin_select_pkg::MODE_SINGLE_CHIP:  d_bus_sel_next = 16'h0000;
      default:                           d_bus_sel_next = 16'h0000;
    endcase
    d_pin_next.out = (d_bus_sel_next & i_d_bus.out) | (~d_bus_sel_next & i_d_gpio.out);
    d_pin_next.oe  = (d_bus_sel_next & i_d_bus.oe) | (~d_bus_sel_next & i_d_gpio.oe);
  end

  assign dma_fn_blocked = SIX_PORTS && (i_op_mode == pin_select_pkg::MODE_SINGLE_CHIP);

  always_comb begin
    e15_fn_next = dec_upper(port_e_upper_function_select_reg[`PSEL_E15_HI:`PSEL_E15_LO],
                            1'b0, dma_fn_blocked);
    e14_fn_next = dec_upper(port_e_upper_function_select_reg[`PSEL_E14_HI:`PSEL_E14_LO],
                            1'b1, dma_fn_blocked);
    // upper pins from first register, lower pins from second
    e_dir_ok_next        = 16'hffff;
    e_dir_ok_next[15]    = (e15_fn_next == pin_select_pkg::FN_GPIO);
    e_dir_ok_next[14]    = (e14_fn_next == pin_select_pkg::FN_GPIO);
    // lower pins 3..0 with high code bit set carry dma request lines
    e_dir_ok_next[3]     = ~port_e_lower_function_select_reg[7];
    e_dir_ok_next[2]     = ~port_e_lower_function_select_reg[5];
    e_dir_ok_next[1]     = ~port_e_lower_function_select_reg[3];
    e_dir_ok_next[0]     = ~port_e_lower_function_select_reg[1];
    e_pin_next.oe        = e_dir_ok_next & port_e_direction_reg;
    e_pin_next.out       = i_e_gpio_out;
    if (e15_fn_next == pin_select_pkg::FN_DMA_ACK) begin
      e_pin_next.oe[15]  = 1'b1;
      e_pin_next.out[15] = i_dma_ch1_acknowledge_out;
    end
    case (e14_fn_next)
      pin_select_pkg::FN_DMA_ACK: begin
        e_pin_next.oe[14]  = 1'b1;
        e_pin_next.out[14] = i_dma_ch0_acknowledge_out;
      end
      pin_select_pkg::FN_ADDR_HOLD: begin
        e_pin_next.oe[14]  = 1'b1;
        e_pin_next.out[14] = i_address_hold_out;
      end
      default: begin
      end
    endcase
  end

  // registered pin drive costs one cycle but keeps outputs glitch free
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_d_pin     <= '0;
      o_d_bus_sel <= 16'h0000;
      o_e_pin     <= '0;
      o_e15_fn    <= pin_select_pkg::FN_GPIO;
      o_e14_fn    <= pin_select_pkg::FN_GPIO;
    end else begin
      o_d_pin     <= d_pin_next;
      o_d_bus_sel <= d_bus_sel_next;
      o_e_pin     <= e_pin_next;
      o_e15_fn    <= e15_fn_next;
      o_e14_fn    <= e14_fn_next;
    end
  end

endmodule

// [sim/port_sel_asserts.sv]
// concurrent checks on the port d/e pin selector ports
`timescale 1ns/10ps
`include "pin_select_map.svh"
module port_sel_asserts #(
  parameter bit SIX_PORTS = 1'b1
) (
  input wire logic                        i_clk,
  input wire logic                        i_nrst,
  input wire pin_select_pkg::op_mode_t    i_op_mode,
  input wire logic [`PSEL_ADDR_W-1:0]     i_addr,
  input wire logic [15:0]                 i_wdata,
  input wire logic                        i_wr,
  input wire logic                        i_rd,
  input wire logic [15:0]                 o_rdata,
  input wire logic                        i_dma_ch1_acknowledge_out,
  input wire logic                        i_address_hold_out,
  input wire pin_select_pkg::pin_drive_t  i_d_gpio,
  input wire pin_select_pkg::pin_drive_t  i_d_bus,
  input wire logic [15:0]                 i_e_gpio_out,
  input wire pin_select_pkg::pin_drive_t  o_d_pin,
  input wire logic [15:0]                 o_d_bus_sel,
  input wire pin_select_pkg::pin_drive_t  o_e_pin,
  input wire pin_select_pkg::e_upper_fn_t o_e15_fn,
  input wire pin_select_pkg::e_upper_fn_t o_e14_fn
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_dir; i_wr && i_addr == `PSEL_OFS_E_DIR ##2 i_rd && i_addr == `PSEL_OFS_E_DIR
    |=> o_rdata == $past(i_wdata, 3); endproperty
  a_dir: assert property (p_dir) else $error("dir readback");
  property p_upr; i_rd && i_addr == `PSEL_OFS_E_UP_FSEL |=> o_rdata[11:0] == 12'h000; endproperty
  a_upr: assert property (p_upr) else $error("upper low bits");
  property p_rst; $rose(i_nrst) |-> o_e_pin.oe == 16'h0000 && o_e15_fn == 2'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_sc; i_op_mode == pin_select_pkg::MODE_SINGLE_CHIP |=> o_d_bus_sel == 16'h0000;
  endproperty
  a_sc: assert property (p_sc) else $error("single chip d");
  property p_rd; i_op_mode == pin_select_pkg::MODE_ROM_DISABLED |=> o_d_bus_sel == 16'hffff;
  endproperty
  a_rd: assert property (p_rd) else $error("rom off d");
  property p_hold; o_e14_fn == pin_select_pkg::FN_ADDR_HOLD
    |-> o_e_pin.oe[14] && o_e_pin.out[14] == $past(i_address_hold_out); endproperty
  a_hold: assert property (p_hold) else $error("hold pin");
  property p_ack; o_e15_fn == pin_select_pkg::FN_DMA_ACK
    |-> o_e_pin.oe[15] && o_e_pin.out[15] == $past(i_dma_ch1_acknowledge_out); endproperty
  a_ack: assert property (p_ack) else $error("ack pin");
  property p_six; SIX_PORTS && i_op_mode == pin_select_pkg::MODE_SINGLE_CHIP
    |=> o_e15_fn == pin_select_pkg::FN_GPIO && o_e14_fn == pin_select_pkg::FN_GPIO; endproperty
  a_six: assert property (p_six) else $error("single chip e");
  // first cycle after reset still shows reset drive, so skip it
  property p_dpin; $past(i_nrst) |-> o_d_pin.out == (($past(i_d_bus.out) & o_d_bus_sel)
    | ($past(i_d_gpio.out) & ~o_d_bus_sel)) && o_d_pin.oe == (($past(i_d_bus.oe) & o_d_bus_sel)
    | ($past(i_d_gpio.oe) & ~o_d_bus_sel)); endproperty
  a_dpin: assert property (p_dpin) else $error("d pin route");
  property p_eout; $past(i_nrst) |-> o_e_pin.out[13:0] == $past(i_e_gpio_out[13:0]);
  endproperty
  a_eout: assert property (p_eout) else $error("e pin data");
endmodule
bind port_d_e_pin_function_select port_sel_asserts #(.SIX_PORTS(SIX_PORTS)) chk_i (.*);

// [sim/periph_model.sv]
// far-side peripheral drive model
`timescale 1ns/10ps
module periph_model (
  input  wire logic                  i_clk,
  output pin_select_pkg::pin_drive_t o_gpio,
  output pin_select_pkg::pin_drive_t o_bus,
  output logic [15:0]                o_e_out,
  output logic [2:0]                 o_ctl
);
  // changes every cycle so a stale route shows
  logic [15:0] cnt_reg = 16'h0000;
  always_ff @(posedge i_clk) begin
    cnt_reg <= cnt_reg + 16'h0001;
  end
  assign o_gpio = {cnt_reg, ~cnt_reg};
  assign o_bus = {~cnt_reg, cnt_reg};
  assign o_e_out = cnt_reg ^ 16'h5a5a;
  assign o_ctl = cnt_reg[2:0];
endmodule

// [sim/tb_top.sv]
// self-checking bench for the port d/e pin selector
`timescale 1ns/10ps
`include "pin_select_map.svh"
module tb_top;
  logic                        i_clk, i_nrst, i_wr, i_rd;
  logic [3:0]                  i_addr;
  logic [15:0]                 i_wdata, o_rdata, o_d_bus_sel, e_out;
  logic [2:0]                  ctl;
  pin_select_pkg::op_mode_t    i_op_mode;
  pin_select_pkg::pin_drive_t  d_gpio, d_bus, o_d_pin, o_e_pin;
  pin_select_pkg::e_upper_fn_t o_e15_fn, o_e14_fn;
  int                          fails = 0, samples_checked = 0;
  // offset, write data, expected read
  logic [35:0] rows [5] = '{36'h0_0f0f_0f0f, 36'h8_1234_0000, 36'h4_ffff_f000,
                            36'h6_0000_0000, 36'h2_8001_8001};
  periph_model far (.i_clk(i_clk), .o_gpio(d_gpio), .o_bus(d_bus), .o_e_out(e_out), .o_ctl(ctl));
  port_d_e_pin_function_select uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_op_mode(i_op_mode),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_d_gpio(d_gpio), .i_d_bus(d_bus), .i_e_gpio_out(e_out),
    .i_dma_ch1_acknowledge_out(ctl[2]), .i_dma_ch0_acknowledge_out(ctl[1]),
    .i_address_hold_out(ctl[0]), .o_d_pin(o_d_pin), .o_d_bus_sel(o_d_bus_sel),
    .o_e_pin(o_e_pin), .o_e15_fn(o_e15_fn), .o_e14_fn(o_e14_fn));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkfn(input string n, input pin_select_pkg::e_upper_fn_t e, g);
    chk(n, {14'h0, e}, {14'h0, g});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk("rdata", e, o_rdata);
  endtask
  // outputs lag the mode by a register stage
  task automatic mode(input pin_select_pkg::op_mode_t m);
    @(posedge i_clk);
    i_op_mode <= m;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #2000;
    fails++;
    give_verdict();
  end
  initial begin
    i_nrst = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 16'h0000;
    i_op_mode = pin_select_pkg::MODE_ROM_ENABLED;
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    foreach (rows[k]) begin
      wr(rows[k][35:32], rows[k][31:16]);
      rd(rows[k][35:32], rows[k][15:0]);
    end
    chk("dsel", 16'h0f0f, o_d_bus_sel);
    chkfn("e14fn", pin_select_pkg::FN_ADDR_HOLD, o_e14_fn);
    chkfn("e15fn", pin_select_pkg::FN_GPIO, o_e15_fn);
    chk("eoe", 16'hc001, o_e_pin.oe);
    mode(pin_select_pkg::MODE_ROM_DISABLED);
    chk("dsel", 16'hffff, o_d_bus_sel);
    mode(pin_select_pkg::MODE_SINGLE_CHIP);
    chk("dsel", 16'h0000, o_d_bus_sel);
    chkfn("e14fn", pin_select_pkg::FN_GPIO, o_e14_fn);
    chk("eoe", 16'h8001, o_e_pin.oe);
    wr(`PSEL_OFS_E_UP_FSEL, 16'h8000);
    mode(pin_select_pkg::MODE_ROM_ENABLED);
    chkfn("e15fn", pin_select_pkg::FN_DMA_ACK, o_e15_fn);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(`PSEL_OFS_E_DIR, 16'h0000);
    rd(`PSEL_OFS_E_UP_FSEL, 16'h0000);
    give_verdict();
  end
endmodule
